// [hw/gcpb_pkg.sv]
// Parameter bank constants: addresses, word indexes, field layout, defaults.
// Assumes 32-bit parameter words reached by an 8-bit parameter address.
`default_nettype none
package gcpb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_WORDS = 13;
    localparam int IDX_W = 4;

    // Parameter addresses
    localparam logic [7:0] ADDR_ID   = 8'h03;
    localparam logic [7:0] ADDR_TOUT = 8'h04;
    localparam logic [7:0] ADDR_RATE = 8'h3d;
    localparam logic [7:0] ADDR_TEMPERATURE_MIDPOINT = 8'h3e;
    localparam logic [7:0] ADDR_SF0  = 8'h3f;
    localparam logic [7:0] ADDR_B1   = 8'h41;
    localparam logic [7:0] ADDR_SF1  = 8'h42;
    localparam logic [7:0] ADDR_B2   = 8'h43;
    localparam logic [7:0] ADDR_SF2  = 8'h44;
    localparam logic [7:0] ADDR_B3   = 8'h45;
    localparam logic [7:0] ADDR_SF3  = 8'h46;
    localparam logic [7:0] ADDR_B4   = 8'h47;
    localparam logic [7:0] ADDR_SF4  = 8'h48;

    // Storage indexes
    localparam logic [3:0] IDX_ID   = 4'h0;
    localparam logic [3:0] IDX_TOUT = 4'h1;
    localparam logic [3:0] IDX_RATE = 4'h2;
    localparam logic [3:0] IDX_TEMPERATURE_MIDPOINT = 4'h3;
    localparam logic [3:0] IDX_SF0  = 4'h4;
    localparam logic [3:0] IDX_B1   = 4'h5;
    localparam logic [3:0] IDX_SF1  = 4'h6;
    localparam logic [3:0] IDX_B2   = 4'h7;
    localparam logic [3:0] IDX_SF2  = 4'h8;
    localparam logic [3:0] IDX_B3   = 4'h9;
    localparam logic [3:0] IDX_SF3  = 4'ha;
    localparam logic [3:0] IDX_B4   = 4'hb;
    localparam logic [3:0] IDX_SF4  = 4'hc;
    localparam logic [3:0] IDX_LAST = 4'hc;

    // Field layout
    localparam int TSEL_BIT  = 3;
    localparam int TOFF_LSB  = 18;
    localparam int TOFF_W    = 14;
    localparam int TGAIN_LSB = 4;
    localparam int TGAIN_W   = 14;
    localparam int RSEL_BIT  = 31;
    localparam int SLOT_LSB  = 8;
    localparam int SLOT_W    = 5;
    localparam int TEMPERATURE_MIDPOINT_W    = 24;
    localparam int SF4_W = 19;
    localparam int SF3_W = 20;
    localparam int SF2_W = 21;
    localparam int SF1_W = 30;
    localparam int SF0_W = 31;
    localparam int B4_W  = 19;
    localparam int B3_W  = 20;
    localparam int B2_W  = 20;
    localparam int B1_W  = 30;
    localparam int SLOTS_LEFT_W = 3;

    // Field defaults
    localparam logic [13:0] TOFF_DEF  = 14'h0000;
    localparam logic [13:0] TGAIN_DEF = 14'h0800;
    localparam logic        TSEL_DEF  = 1'b0;
    localparam logic        RSEL_DEF  = 1'b1;
    localparam logic [4:0]  SLOT_DEF  = 5'h01;
    localparam logic [4:0]  SLOT_FULL = 5'h1f;

    localparam logic [31:0] TOUT_WORD_DEF =
        (32'(TOFF_DEF) << TOFF_LSB) | (32'(TGAIN_DEF) << TGAIN_LSB) |
        (32'(TSEL_DEF) << TSEL_BIT);
    localparam logic [31:0] RATE_WORD_DEF =
        (32'(RSEL_DEF) << RSEL_BIT) | (32'(SLOT_DEF) << SLOT_LSB);

    typedef logic [3:0] gcpb_index_type;

    function automatic gcpb_index_type addr_to_index(
        input logic [7:0] addr
    );
        case (addr)
            ADDR_ID:   addr_to_index = IDX_ID;
            ADDR_TOUT: addr_to_index = IDX_TOUT;
            ADDR_RATE: addr_to_index = IDX_RATE;
            ADDR_TEMPERATURE_MIDPOINT: addr_to_index = IDX_TEMPERATURE_MIDPOINT;
            ADDR_SF0:  addr_to_index = IDX_SF0;
            ADDR_B1:   addr_to_index = IDX_B1;
            ADDR_SF1:  addr_to_index = IDX_SF1;
            ADDR_B2:   addr_to_index = IDX_B2;
            ADDR_SF2:  addr_to_index = IDX_SF2;
            ADDR_B3:   addr_to_index = IDX_B3;
            ADDR_SF3:  addr_to_index = IDX_SF3;
            ADDR_B4:   addr_to_index = IDX_B4;
            ADDR_SF4:  addr_to_index = IDX_SF4;
            default:   addr_to_index = 4'hf;
        endcase
    endfunction

    function automatic logic [7:0] index_to_addr(input gcpb_index_type idx);
        case (idx)
            IDX_ID:   index_to_addr = ADDR_ID;
            IDX_TOUT: index_to_addr = ADDR_TOUT;
            IDX_RATE: index_to_addr = ADDR_RATE;
            IDX_TEMPERATURE_MIDPOINT: index_to_addr = ADDR_TEMPERATURE_MIDPOINT;
            IDX_SF0:  index_to_addr = ADDR_SF0;
            IDX_B1:   index_to_addr = ADDR_B1;
            IDX_SF1:  index_to_addr = ADDR_SF1;
            IDX_B2:   index_to_addr = ADDR_B2;
            IDX_SF2:  index_to_addr = ADDR_SF2;
            IDX_B3:   index_to_addr = ADDR_B3;
            IDX_SF3:  index_to_addr = ADDR_SF3;
            IDX_B4:   index_to_addr = ADDR_B4;
            default:  index_to_addr = ADDR_SF4;
        endcase
    endfunction

    function automatic logic [31:0] word_default(input gcpb_index_type idx);
        case (idx)
            IDX_TOUT: word_default = TOUT_WORD_DEF;
            IDX_RATE: word_default = RATE_WORD_DEF;
            default:  word_default = 32'h0000_0000;
        endcase
    endfunction

endpackage
`default_nettype wire

// [hw/gcpb_nv_loader.sv]
// Walks every parameter word and fetches its non-volatile copy after reset.
// Assumes the memory answers each held request with a one-cycle valid.
`default_nettype none
module gcpb_nv_loader (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    output logic [7:0]                nv_addr_o,
    output logic                      nv_rd_o,
    input  wire logic [31:0]          nv_rdata_i,
    input  wire logic                 nv_rvalid_i,
    output logic                      ld_we_o,
    output gcpb_pkg::gcpb_index_type  ld_index_o,
    output logic [31:0]               ld_data_o,
    output logic                      done_o
);

    typedef enum logic [1:0] {
        GCPB_LD_REQ,
        GCPB_LD_NEXT,
        GCPB_LD_DONE
    } gcpb_ld_state_type;

    gcpb_ld_state_type        state;
    gcpb_pkg::gcpb_index_type index;

    assign nv_addr_o = gcpb_pkg::index_to_addr(index);
    assign nv_rd_o   = (state == GCPB_LD_REQ);
    assign done_o    = (state == GCPB_LD_DONE);

    ////////////////////////////////////////////////////////////////////////
    // One word per handshake; the request holds until the memory answers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= GCPB_LD_REQ;
            index      <= gcpb_pkg::IDX_ID;
            ld_we_o    <= 1'b0;
            ld_index_o <= gcpb_pkg::IDX_ID;
            ld_data_o  <= 32'h0000_0000;
        end else begin
            ld_we_o <= 1'b0;
            case (state)
                GCPB_LD_REQ: begin
                    if (nv_rvalid_i) begin
                        ld_we_o    <= 1'b1; // [RQ14]
                        ld_index_o <= index;
                        ld_data_o  <= nv_rdata_i;
                        state      <= GCPB_LD_NEXT;
                    end
                end
                GCPB_LD_NEXT: begin
                    if (index == gcpb_pkg::IDX_LAST) begin
                        state <= GCPB_LD_DONE;
                    end else begin
                        index <= index + 4'h1;
                        state <= GCPB_LD_REQ;
                    end
                end
                GCPB_LD_DONE: state <= GCPB_LD_DONE;
                default:      state <= GCPB_LD_REQ;
            endcase
        end
    end

endmodule
`default_nettype wire

// [hw/gcpb_slot_decode.sv]
// Turns the thermometer-coded slot count into slots remaining.
// Pure combinational; the caller registers the result.
`default_nettype none
module gcpb_slot_decode (
    input  wire logic [4:0] count_i,
    output logic [2:0]      remaining_o,
    output logic            legal_o
);

    // Unprogrammed parts also report no slot usable
    always_comb begin
        legal_o = 1'b1;
        case (count_i) // [RQ6]
            5'h00:   remaining_o = 3'h0;
            5'h01:   remaining_o = 3'h4;
            5'h03:   remaining_o = 3'h3;
            5'h07:   remaining_o = 3'h2;
            5'h0f:   remaining_o = 3'h1;
            5'h1f:   remaining_o = 3'h0;
            default: begin
                remaining_o = 3'h0;
                legal_o     = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// [hw/gcpb_param_bank.sv]
// Calibration parameter bank of the yaw-rate sensor: volatile word store,
// reloaded from non-volatile memory at reset, with a word access port.
// Assumes the serial command decoder outside presents word-level accesses.
`default_nettype none

// Functional notes
// (RQ1) Word 0x03 holds the 32-bit unique part identifier, read only.
// (RQ2) Bit 3 of word 0x04 selects calibrated temperature; default zero.
// (RQ3) Bits 31:18 of word 0x04 hold temperature offset; default zero.
// (RQ4) Bits 17:4 of word 0x04 hold temperature gain; default 0x0800.
// (RQ5) Bit 31 of word 0x3D selects compensated rate; default one.
// (RQ6) Bits 12:8 of word 0x3D: thermometer slot count, default 00001.
// (RQ7) Scale coefficients at 0x48,0x46,0x44,0x42,0x3F, low fields.
// (RQ8) Bias coefficients at 0x47,0x45,0x43,0x41, low fields.
// (RQ9) Host rewrites bits outside a field with the value read back.
// (RQ10) Parameters reachable through the serial command interface.
// (RQ11) Written values vanish at reset; stored values reload; rewritable.
// (RQ12) Host programs rate coefficients at most five times, others once.
// (RQ13) Device is a mode-0 serial slave; host drives that mode.
// (RQ14) At reset every field loads from non-volatile copy before use.
module gcpb_param_bank (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Word access from the serial command decoder
    input  wire logic [7:0]  acc_addr_i,
    input  wire logic        acc_wr_i,
    input  wire logic [31:0] acc_wdata_i,
    input  wire logic        acc_rd_i,
    output logic [31:0]      acc_rdata_o,
    output logic             acc_rvalid_o,
    output logic             acc_wack_o,
    output logic             acc_err_o,
    // Non-volatile memory read port
    output logic [7:0]       nv_addr_o,
    output logic             nv_rd_o,
    input  wire logic [31:0] nv_rdata_i,
    input  wire logic        nv_rvalid_i,
    // Parameters to the data paths
    output logic             params_valid_o,
    output logic [31:0]      unique_id_o,
    output logic             calibrated_temperature_select_o,
    output logic [13:0]      temperature_offset_o,
    output logic [13:0]      temperature_gain_o,
    output logic             compensated_rate_select_o,
    output logic [4:0]       nonvolatile_slot_count_o,
    output logic [2:0]       slots_remaining_o,
    output logic             slot_count_legal_o,
    output logic [23:0]      temperature_midpoint_o,
    output logic [30:0]      scale_constant_coefficient_o,
    output logic [29:0]      scale_first_order_coefficient_o,
    output logic [20:0]      scale_second_order_coefficient_o,
    output logic [19:0]      scale_third_order_coefficient_o,
    output logic [18:0]      scale_fourth_order_coefficient_o,
    output logic [29:0]      bias_first_order_coefficient_o,
    output logic [19:0]      bias_second_order_coefficient_o,
    output logic [19:0]      bias_third_order_coefficient_o,
    output logic [18:0]      bias_fourth_order_coefficient_o
);

    logic [31:0]              words [gcpb_pkg::NUM_WORDS];
    logic                     ld_we;
    gcpb_pkg::gcpb_index_type ld_index;
    logic [31:0]              ld_data;
    logic                     ld_done;
    gcpb_pkg::gcpb_index_type acc_index;
    logic                     acc_mapped;
    logic                     wr_ok;
    logic [2:0]               next_remaining;
    logic                     next_legal;

    ////////////////////////////////////////////////////////////////////////
    // Reload from non-volatile memory
    gcpb_nv_loader u_loader (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .nv_addr_o   (nv_addr_o),
        .nv_rd_o     (nv_rd_o),
        .nv_rdata_i  (nv_rdata_i),
        .nv_rvalid_i (nv_rvalid_i),
        .ld_we_o     (ld_we),
        .ld_index_o  (ld_index),
        .ld_data_o   (ld_data),
        .done_o      (ld_done)
    );

    gcpb_slot_decode u_slot (
        .count_i     (words[gcpb_pkg::IDX_RATE][gcpb_pkg::SLOT_LSB +:
                                                gcpb_pkg::SLOT_W]),
        .remaining_o (next_remaining),
        .legal_o     (next_legal)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access decode; the serial side is the mode-0 slave outside [RQ13]
    assign acc_index  = gcpb_pkg::addr_to_index(acc_addr_i); // [RQ10]
    assign acc_mapped = (acc_index <= gcpb_pkg::IDX_LAST);
    // Identifier is read only; writes during reload are refused
    assign wr_ok = acc_wr_i && acc_mapped && ld_done &&
                   (acc_index != gcpb_pkg::IDX_ID); // [RQ1]

    ////////////////////////////////////////////////////////////////////////
    // Word store: whole words kept, so bits outside fields read back as
    // written and the host read-modify-write holds them [RQ9]
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < gcpb_pkg::NUM_WORDS; i++) begin
                words[i] <= gcpb_pkg::word_default(
                    gcpb_pkg::gcpb_index_type'(i)); // [RQ11]
            end
        end else if (ld_we) begin
            words[ld_index] <= ld_data; // [RQ14]
        end else if (wr_ok) begin
            words[acc_index] <= acc_wdata_i; // [RQ11] [RQ7] [RQ8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access answers, one cycle after the request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_rdata_o  <= 32'h0000_0000;
            acc_rvalid_o <= 1'b0;
            acc_wack_o   <= 1'b0;
            acc_err_o    <= 1'b0;
        end else begin
            acc_rvalid_o <= acc_rd_i;
            acc_wack_o   <= wr_ok;
            acc_err_o    <= (acc_rd_i && !acc_mapped) ||
                            (acc_wr_i && !wr_ok);
            if (acc_rd_i && acc_mapped) begin
                acc_rdata_o <= words[acc_index]; // [RQ1] [RQ10]
            end else begin
                acc_rdata_o <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered slot status, one cycle behind the slot field
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slots_remaining_o  <= 3'h0;
            slot_count_legal_o <= 1'b0;
        end else begin
            slots_remaining_o  <= next_remaining; // [RQ6]
            slot_count_legal_o <= next_legal;
        end
    end

    // Data paths must ignore the fields until the reload is over
    assign params_valid_o = ld_done; // [RQ14]

    ////////////////////////////////////////////////////////////////////////
    // Field outputs, straight slices of the word flip-flops
    assign unique_id_o = words[gcpb_pkg::IDX_ID]; // [RQ1]
    assign calibrated_temperature_select_o =
        words[gcpb_pkg::IDX_TOUT][gcpb_pkg::TSEL_BIT]; // [RQ2]
    assign temperature_offset_o =
        words[gcpb_pkg::IDX_TOUT][gcpb_pkg::TOFF_LSB +:
                                  gcpb_pkg::TOFF_W]; // [RQ3]
    assign temperature_gain_o =
        words[gcpb_pkg::IDX_TOUT][gcpb_pkg::TGAIN_LSB +:
                                  gcpb_pkg::TGAIN_W]; // [RQ4]
    assign compensated_rate_select_o =
        words[gcpb_pkg::IDX_RATE][gcpb_pkg::RSEL_BIT]; // [RQ5]
    assign nonvolatile_slot_count_o =
        words[gcpb_pkg::IDX_RATE][gcpb_pkg::SLOT_LSB +:
                                  gcpb_pkg::SLOT_W]; // [RQ6]
    assign temperature_midpoint_o =
        words[gcpb_pkg::IDX_TEMPERATURE_MIDPOINT][gcpb_pkg::TEMPERATURE_MIDPOINT_W-1:0];
    assign scale_constant_coefficient_o =
        words[gcpb_pkg::IDX_SF0][gcpb_pkg::SF0_W-1:0]; // [RQ7]
    assign scale_first_order_coefficient_o =
        words[gcpb_pkg::IDX_SF1][gcpb_pkg::SF1_W-1:0]; // [RQ7]
    assign scale_second_order_coefficient_o =
        words[gcpb_pkg::IDX_SF2][gcpb_pkg::SF2_W-1:0]; // [RQ7]
    assign scale_third_order_coefficient_o =
        words[gcpb_pkg::IDX_SF3][gcpb_pkg::SF3_W-1:0]; // [RQ7]
    assign scale_fourth_order_coefficient_o =
        words[gcpb_pkg::IDX_SF4][gcpb_pkg::SF4_W-1:0]; // [RQ7]
    assign bias_first_order_coefficient_o =
        words[gcpb_pkg::IDX_B1][gcpb_pkg::B1_W-1:0]; // [RQ8]
    assign bias_second_order_coefficient_o =
        words[gcpb_pkg::IDX_B2][gcpb_pkg::B2_W-1:0]; // [RQ8]
    assign bias_third_order_coefficient_o =
        words[gcpb_pkg::IDX_B3][gcpb_pkg::B3_W-1:0]; // [RQ8]
    assign bias_fourth_order_coefficient_o =
        words[gcpb_pkg::IDX_B4][gcpb_pkg::B4_W-1:0]; // [RQ8]

    ////////////////////////////////////////////////////////////////////////
    // Checks
    id_read_back_a: assert property ( // [RQ1]
        @(posedge clk_i) disable iff (!rst_n_i)
        acc_rd_i && acc_addr_i == gcpb_pkg::ADDR_ID
        |=> acc_rvalid_o && acc_rdata_o == $past(unique_id_o))
        else $error("identifier read back wrong");

    id_read_only_a: assert property ( // [RQ1]
        @(posedge clk_i) disable iff (!rst_n_i)
        acc_wr_i && acc_addr_i == gcpb_pkg::ADDR_ID && !ld_we
        |=> $stable(unique_id_o) && acc_err_o && !acc_wack_o)
        else $error("identifier changed by a write");

    temp_select_a: assert property ( // [RQ2]
        @(posedge clk_i) disable iff (!rst_n_i)
        ld_done && acc_wr_i && acc_addr_i == gcpb_pkg::ADDR_TOUT
        |=> calibrated_temperature_select_o == $past(acc_wdata_i[3]))
        else $error("temperature select not taken");

    temp_fields_a: assert property ( // [RQ3] [RQ4]
        @(posedge clk_i) disable iff (!rst_n_i)
        ld_done && acc_wr_i && acc_addr_i == gcpb_pkg::ADDR_TOUT
        |=> temperature_offset_o == $past(acc_wdata_i[31:18]) &&
            temperature_gain_o == $past(acc_wdata_i[17:4]))
        else $error("temperature calibration fields wrong");

    rate_select_a: assert property ( // [RQ5]
        @(posedge clk_i) disable iff (!rst_n_i)
        ld_done && acc_wr_i && acc_addr_i == gcpb_pkg::ADDR_RATE
        |=> compensated_rate_select_o == $past(acc_wdata_i[31]))
        else $error("rate select not taken");

    slot_full_a: assert property ( // [RQ6]
        @(posedge clk_i) disable iff (!rst_n_i)
        ld_done && acc_wr_i && acc_addr_i == gcpb_pkg::ADDR_RATE &&
        acc_wdata_i[12:8] == 5'h1f
        |=> ##1 slots_remaining_o == 3'h0 && slot_count_legal_o)
        else $error("full slot count misdecoded");

    coef_whole_word_a: assert property ( // [RQ7] [RQ9]
        @(posedge clk_i) disable iff (!rst_n_i)
        ld_done && acc_wr_i && acc_addr_i == gcpb_pkg::ADDR_SF4
        ##1 !acc_wr_i
        ##1 acc_rd_i && acc_addr_i == gcpb_pkg::ADDR_SF4 && !acc_wr_i
        |=> acc_rdata_o == $past(acc_wdata_i, 3))
        else $error("coefficient word not kept whole");

    bias_field_a: assert property ( // [RQ8]
        @(posedge clk_i) disable iff (!rst_n_i)
        ld_done && acc_wr_i && acc_addr_i == gcpb_pkg::ADDR_B1
        |=> bias_first_order_coefficient_o == $past(acc_wdata_i[29:0]))
        else $error("bias first order field wrong");

    unmapped_read_a: assert property ( // [RQ10]
        @(posedge clk_i) disable iff (!rst_n_i)
        acc_rd_i && acc_addr_i == 8'h40
        |=> acc_err_o && acc_rvalid_o && acc_rdata_o == 32'h0000_0000)
        else $error("unmapped read not flagged");

    load_blocks_write_a: assert property ( // [RQ14]
        @(posedge clk_i) disable iff (!rst_n_i)
        !params_valid_o && acc_wr_i |=> acc_err_o && !acc_wack_o)
        else $error("write accepted during reload");

    valid_sticks_a: assert property ( // [RQ14] [RQ11]
        @(posedge clk_i) disable iff (!rst_n_i)
        params_valid_o |=> params_valid_o)
        else $error("parameter valid dropped");

    slot_zero_a: assert property ( // [RQ6]
        @(posedge clk_i) disable iff (!rst_n_i)
        nonvolatile_slot_count_o == 5'h00
        |=> slot_count_legal_o &&
            slots_remaining_o == 3'h0)
        else $error("slot zero misread");

    slot_once_a: assert property ( // [RQ6]
        @(posedge clk_i) disable iff (!rst_n_i)
        nonvolatile_slot_count_o == 5'h01
        |=> slot_count_legal_o &&
            slots_remaining_o == 3'h4)
        else $error("slot one misread");

    slot_twice_a: assert property ( // [RQ6]
        @(posedge clk_i) disable iff (!rst_n_i)
        nonvolatile_slot_count_o == 5'h03
        |=> slot_count_legal_o &&
            slots_remaining_o == 3'h3)
        else $error("slot two misread");

    slot_bad_code_a: assert property ( // [RQ6]
        @(posedge clk_i) disable iff (!rst_n_i)
        nonvolatile_slot_count_o == 5'h05
        |=> !slot_count_legal_o &&
            slots_remaining_o == 3'h0)
        else $error("bad slot code taken");

    reload_data_a: assert property ( // [RQ14]
        @(posedge clk_i) disable iff (!rst_n_i)
        ld_we
        |=> words[$past(ld_index)] ==
            $past(ld_data))
        else $error("reloaded word lost");

    nv_hold_a: assert property ( // [RQ14]
        @(posedge clk_i) disable iff (!rst_n_i)
        nv_rd_o && !nv_rvalid_i
        |=> nv_rd_o &&
            $stable(nv_addr_o))
        else $error("reload request dropped");

endmodule
`default_nettype wire

// [bench/gcpb_nv_model.sv]
// Non-volatile memory model answering the bank's reload fetches.
// Assumes the request is held until the one-cycle valid is seen.
`default_nettype none
module gcpb_nv_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  nv_addr_i,
    input  wire logic        nv_rd_i,
    output logic [31:0]      nv_rdata_o,
    output logic             nv_rvalid_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] cnt;
    ////////////////////////////////////////
    // Odd words answer at once, even ones after three edges
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt         <= 2'h0;
            nv_rvalid_o <= 1'b0;
            nv_rdata_o  <= 32'h0000_0000;
        end else if (nv_rd_i && !nv_rvalid_o &&
                     cnt == {2{!nv_addr_i[0]}}) begin
            nv_rvalid_o <= 1'b1;
            nv_rdata_o  <= {nv_addr_i, ~nv_addr_i, nv_addr_i ^ 8'h3c, 8'h96};
        end else begin
            // Stale data toggles so it is never taken for a word
            nv_rvalid_o <= 1'b0;
            nv_rdata_o  <= ~nv_rdata_o;
            cnt         <= nv_rd_i ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Bench for the parameter bank: reload, field layout, slot decode.
// Assumes gcpb_nv_model supplies the words fetched after reset.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, rd, wr, pv, nv_rd, nv_rv, rv, wack, err;
    logic        tsel, rsel, legal;
    logic [2:0]  resp, rem;
    logic [4:0]  slot;
    logic [7:0]  addr, nv_addr;
    logic [13:0] toff, tgain;
    logic [23:0] mid;
    logic [30:0] sc0;
    logic [29:0] sc1, bi1;
    logic [20:0] sc2;
    logic [19:0] sc3, bi2, bi3;
    logic [18:0] sc4, bi4;
    logic [31:0] wdata, rdata, nv_rdata, uid, got, w, e;
    logic [31:0] outs [13];
    int          num_errors = 0;
    int          n_checks = 0;
    localparam logic [7:0] MAP [13] = '{8'h03, 8'h04, 8'h3d, 8'h3e,
        8'h3f, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48};
    localparam logic [31:0] MSK [13] = '{32'hffffffff, 32'hfffffff8,
        32'h80001f00, 32'h00ffffff, 32'h7fffffff, 32'h3fffffff,
        32'h3fffffff, 32'h000fffff, 32'h001fffff, 32'h000fffff,
        32'h000fffff, 32'h0007ffff, 32'h0007ffff};
    // {code, slots left, legal}; the last code is not a thermometer
    localparam logic [8:0] SLOTS [7] = '{9'h001, 9'h019, 9'h037,
        9'h075, 9'h0f3, 9'h1f1, 9'h050};
    ////////////////////////////////////////
    gcpb_param_bank i_gcpb_param_bank (
        .clk_i(clk), .rst_n_i(rst_n), .acc_addr_i(addr), .acc_wr_i(wr),
        .acc_wdata_i(wdata), .acc_rd_i(rd), .acc_rdata_o(rdata),
        .acc_rvalid_o(rv), .acc_wack_o(wack), .acc_err_o(err),
        .nv_addr_o(nv_addr), .nv_rd_o(nv_rd), .nv_rdata_i(nv_rdata),
        .nv_rvalid_i(nv_rv), .params_valid_o(pv), .unique_id_o(uid),
        .calibrated_temperature_select_o(tsel),
        .temperature_offset_o(toff), .temperature_gain_o(tgain),
        .compensated_rate_select_o(rsel),
        .nonvolatile_slot_count_o(slot), .slots_remaining_o(rem),
        .slot_count_legal_o(legal), .temperature_midpoint_o(mid),
        .scale_constant_coefficient_o(sc0),
        .scale_first_order_coefficient_o(sc1),
        .scale_second_order_coefficient_o(sc2),
        .scale_third_order_coefficient_o(sc3),
        .scale_fourth_order_coefficient_o(sc4),
        .bias_first_order_coefficient_o(bi1),
        .bias_second_order_coefficient_o(bi2),
        .bias_third_order_coefficient_o(bi3),
        .bias_fourth_order_coefficient_o(bi4));
    gcpb_nv_model i_gcpb_nv_model (.clk_i(clk), .rst_n_i(rst_n),
        .nv_addr_i(nv_addr), .nv_rd_i(nv_rd), .nv_rdata_o(nv_rdata),
        .nv_rvalid_o(nv_rv));
    // Field outputs placed back at their word positions, in MAP order
    assign outs = '{uid, {toff, tgain, tsel, 3'h0},
        {rsel, 18'h0, slot, 8'h00}, 32'(mid), 32'(sc0), 32'(bi1),
        32'(sc1), 32'(bi2), 32'(sc2), 32'(bi3), 32'(sc3), 32'(bi4),
        32'(sc4)};
    ////////////////////////////////////////
    function automatic logic [31:0] nvw(input logic [7:0] a);
        return {a, ~a, a ^ 8'h3c, 8'h96};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // Answers are sampled half a cycle after the taking edge
    task automatic acc(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        @(negedge clk);
        wr = we;
        rd = !we;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        got = rdata;
        resp = {rv, wack, err};
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        acc(1'b1, 8'h04, 32'h0);
        chk(32'(resp), 32'h1);
        for (int i = 0; i < 400 && pv !== 1'b1; i++) @(negedge clk);
        chk(32'(pv), 32'h1);
    endtask
    task automatic t_reload;
        foreach (MAP[i]) begin
            acc(1'b0, MAP[i], 32'h0);
            chk(32'(resp), 32'h4);
            chk(got, nvw(MAP[i]));
            chk(outs[i], nvw(MAP[i]) & MSK[i]);
        end
    endtask
    // Only the field is flipped; the rest is written back as read
    task automatic t_fields;
        foreach (MAP[i]) begin
            acc(1'b0, MAP[i], 32'h0);
            w = got;
            e = MAP[i] == 8'h03 ? w : w ^ MSK[i];
            acc(1'b1, MAP[i], w ^ MSK[i]);
            chk(32'(resp), MAP[i] == 8'h03 ? 32'h1 : 32'h2);
            chk(outs[i], e & MSK[i]);
            acc(1'b0, MAP[i], 32'h0);
            chk(got, e);
        end
        acc(1'b0, 8'h40, 32'h0);
        chk(32'(resp), 32'h5);
        chk(got, 32'h0);
        acc(1'b1, 8'h40, 32'h0);
        chk(32'(resp), 32'h1);
    endtask
    task automatic t_slots;
        foreach (SLOTS[i]) begin // Seven codes, so seven writes of the rate word
            acc(1'b0, 8'h3d, 32'h0);
            acc(1'b1, 8'h3d, {got[31:13], SLOTS[i][8:4], got[7:0]});
            @(negedge clk);
            chk(32'(legal), 32'(SLOTS[i][0]));
            if (SLOTS[i][0]) chk(32'(rem), 32'(SLOTS[i][3:1]));
        end
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is under a thousand cycles; twenty thousand is ample
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        do_reset();
        t_reload();
        t_fields();
        t_slots();
        do_reset();
        t_reload();
        give_verdict();
    end
endmodule
`default_nettype wire
